// ==== verilog/dpr_pkg.sv ====
// constants and types for the host controller of one dual-port ram port
// assumes a single 125 MHz clock; pin timing held as ns figures below
// Notes on behaviour
// - write strobe high whenever address changes
// - array access: chip enable low, byte select, token high
// - token access: chip enable high, token select low
// - never drive data while device drives it
// - address valid before chip enable falls
// - token reads framed by their own select pulse
// - chip enable high through token write and read-back
`default_nettype none

package dpr_pkg;
   localparam int DPR_ADDR_W = 13;
   localparam int DPR_DATA_W = 16;
   localparam int DPR_CLK_NS = 8;
   // pin timing, ns, slowest speed grade assumed
   localparam int DPR_T_PULSE_NS = 40;
   localparam int DPR_T_ACCESS_NS = 55;
   localparam int DPR_T_RECOVER_NS = 20;
   localparam int DPR_SYNC_CYC = 3;
   localparam logic [7:0] DPR_PULSE_CYC =
      8'((DPR_T_PULSE_NS + DPR_CLK_NS - 1) / DPR_CLK_NS);
   localparam logic [7:0] DPR_READ_CYC =
      8'((DPR_T_ACCESS_NS + DPR_CLK_NS - 1) / DPR_CLK_NS + DPR_SYNC_CYC);
   localparam logic [7:0] DPR_RECOVER_CYC =
      8'((DPR_T_RECOVER_NS + DPR_CLK_NS - 1) / DPR_CLK_NS);
   localparam logic [1:0] DPR_BE_NONE = 2'h0;
   localparam int DPR_BE_UPPER = 1;
   localparam int DPR_BE_LOWER = 0;
   localparam int DPR_TOKEN_BIT = 0;

   typedef enum logic [1:0] {
      DPR_K_ARD = 2'h0,
      DPR_K_AWR = 2'h1,
      DPR_K_TREQ = 2'h2,
      DPR_K_TREL = 2'h3
   } dpr_kind_t;

   typedef enum logic [6:0] {
      DPR_S_IDLE = 7'h01,
      DPR_S_ADR = 7'h02,
      DPR_S_SEL = 7'h04,
      DPR_S_WRT = 7'h08,
      DPR_S_REL = 7'h10,
      DPR_S_RD = 7'h20,
      DPR_S_GAP = 7'h40
   } dpr_state_t;
endpackage : dpr_pkg

`default_nettype wire

// ==== verilog/dpr_sync.sv ====
// three-stage input synchroniser with per-bit agreement filter
// assumes inputs are asynchronous pins; reset is synchronous
`default_nettype none

module dpr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // pins in, filtered level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } dpr_sync_t;

   dpr_sync_t r_reg;
   dpr_sync_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      // a bit moves only once stages two and three agree
      r_next.q = (r_reg.s2 & r_reg.s3) | (r_reg.q & (r_reg.s2 | r_reg.s3));
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.q;
endmodule : dpr_sync

`default_nettype wire

// ==== verilog/dpr_host.sv ====
// host-side controller for one port of an asynchronous dual-port ram
// assumes the device is master (collision pin driven by it) and that
// the board resolves the shared data wire from ram_dq_oe
`default_nettype none

module dpr_host
   import dpr_pkg::*;
#(
   parameter int AW = dpr_pkg::DPR_ADDR_W,
   parameter int DW = dpr_pkg::DPR_DATA_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // command side
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire dpr_pkg::dpr_kind_t cmd_kind,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [DW-1:0] cmd_wdata,
   input wire logic [1:0] cmd_be,
   // response side
   output logic rsp_valid,
   output logic [DW-1:0] rsp_rdata,
   output logic rsp_granted,
   output logic rsp_busy,
   output logic mbox_int,
   // device pins
   output logic [AW-1:0] ram_addr,
   output logic [DW-1:0] ram_dq_o,
   input wire logic [DW-1:0] ram_dq_i,
   output logic ram_dq_oe,
   output logic chip_enable_n,
   output logic token_select_n,
   output logic write_strobe_n,
   output logic output_enable_n,
   output logic upper_byte_select_n,
   output logic lower_byte_select_n,
   input wire logic collision_n,
   input wire logic mailbox_int_n
);
   import dpr_pkg::*;

   typedef struct packed {
      dpr_state_t st;
      dpr_kind_t kind;
      logic rdback;
      logic [1:0] be;
      logic [7:0] cnt;
      logic [AW-1:0] addr;
      logic [DW-1:0] dout;
      logic doe;
      logic ce_n;
      logic sem_n;
      logic rw_n;
      logic oe_n;
      logic upper_sel_n;
      logic lower_sel_n;
      logic mbox;
      logic cmd_ready;
      logic rsp_valid;
      logic [DW-1:0] rdata;
      logic granted;
      logic busy;
   } dpr_host_t;

   localparam dpr_host_t RST = '{st: DPR_S_IDLE, kind: DPR_K_ARD, rdback: 1'b0,
      be: 2'h0, cnt: 8'h00, addr: '0, dout: '0, doe: 1'b0, ce_n: 1'b1,
      sem_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1, upper_sel_n: 1'b1, lower_sel_n: 1'b1,
      mbox: 1'b0, cmd_ready: 1'b1, rsp_valid: 1'b0, rdata: '0, granted: 1'b0, busy: 1'b0};

   dpr_host_t r_reg;
   dpr_host_t r_next;
   logic [DW+1:0] syn_q;
   logic busy_n_s;
   logic is_token;

   dpr_sync #(
      .W(DW + 2),
      .RST_VAL({2'h3, {DW{1'b0}}})
   ) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .d({collision_n, mailbox_int_n, ram_dq_i}),
      .q(syn_q)
   );

   assign busy_n_s = syn_q[DW+1];
   assign is_token = (r_reg.kind == DPR_K_TREQ) || (r_reg.kind == DPR_K_TREL);

   always_comb begin
      r_next = r_reg;
      r_next.rsp_valid = 1'b0;
      // extra flop so the flag output comes straight from a register
      r_next.mbox = !syn_q[DW];
      if (!r_reg.ce_n && !busy_n_s) begin
         r_next.busy = 1'b1;
      end
      case (r_reg.st)
         DPR_S_IDLE: begin
            if (cmd_valid && r_reg.cmd_ready) begin
               r_next.kind = cmd_kind;
               r_next.be = cmd_be;
               r_next.rdback = 1'b0;
               r_next.busy = 1'b0;
               r_next.granted = 1'b0;
               r_next.rdata = '0;
               if (cmd_kind == DPR_K_AWR && cmd_be == DPR_BE_NONE) begin
                  // nothing to write: answer at once
                  r_next.rsp_valid = 1'b1;
               end else begin
                  // address moves only here, strobe high and port idle
                  r_next.addr = cmd_addr;
                  r_next.cmd_ready = 1'b0;
                  r_next.st = DPR_S_ADR;
                  case (cmd_kind)
                     DPR_K_TREQ: r_next.dout = '0;
                     DPR_K_TREL: r_next.dout = '1;
                     default: r_next.dout = cmd_wdata;
                  endcase
               end
            end
         end
         DPR_S_ADR: begin
            // address has stood a full cycle before any select falls
            if (is_token) begin
               r_next.sem_n = 1'b0;
               r_next.lower_sel_n = r_reg.rdback;
            end else begin
               r_next.ce_n = 1'b0;
               r_next.upper_sel_n = !(r_reg.be[DPR_BE_UPPER] || r_reg.be == DPR_BE_NONE);
               r_next.lower_sel_n = !(r_reg.be[DPR_BE_LOWER] || r_reg.be == DPR_BE_NONE);
            end
            if (r_reg.kind == DPR_K_ARD || r_reg.rdback) begin
               r_next.oe_n = 1'b0;
               r_next.cnt = DPR_READ_CYC;
               r_next.st = DPR_S_RD;
            end else begin
               r_next.st = DPR_S_SEL;
            end
         end
         DPR_S_SEL: begin
            // hold an array write's strobe off while the device flags a clash
            if (busy_n_s || is_token) begin
               r_next.rw_n = 1'b0;
               r_next.doe = 1'b1;
               r_next.cnt = DPR_PULSE_CYC;
               r_next.st = DPR_S_WRT;
            end
         end
         DPR_S_WRT: begin
            if (r_reg.cnt == 8'h01) begin
               r_next.rw_n = 1'b1;
               r_next.st = DPR_S_REL;
            end else begin
               r_next.cnt = r_reg.cnt - 8'h01;
            end
         end
         DPR_S_REL: begin
            // data held one cycle past the strobe edge
            r_next.ce_n = 1'b1;
            r_next.sem_n = 1'b1;
            r_next.upper_sel_n = 1'b1;
            r_next.lower_sel_n = 1'b1;
            r_next.doe = 1'b0;
            r_next.cnt = DPR_RECOVER_CYC;
            r_next.st = DPR_S_GAP;
         end
         DPR_S_RD: begin
            if (r_reg.cnt == 8'h01) begin
               r_next.rdata = syn_q[DW-1:0];
               r_next.ce_n = 1'b1;
               r_next.sem_n = 1'b1;
               r_next.oe_n = 1'b1;
               r_next.upper_sel_n = 1'b1;
               r_next.lower_sel_n = 1'b1;
               r_next.cnt = DPR_RECOVER_CYC;
               r_next.st = DPR_S_GAP;
            end else begin
               r_next.cnt = r_reg.cnt - 8'h01;
            end
         end
         DPR_S_GAP: begin
            if (r_reg.cnt != 8'h01) begin
               r_next.cnt = r_reg.cnt - 8'h01;
            end else if (r_reg.kind == DPR_K_TREQ && !r_reg.rdback) begin
               r_next.rdback = 1'b1;
               r_next.st = DPR_S_ADR;
            end else begin
               r_next.granted = (r_reg.kind == DPR_K_TREQ) &&
                  !r_reg.rdata[DPR_TOKEN_BIT];
               r_next.rsp_valid = 1'b1;
               r_next.cmd_ready = 1'b1;
               r_next.st = DPR_S_IDLE;
            end
         end
         default: begin
            r_next = RST;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r_reg <= RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign cmd_ready = r_reg.cmd_ready;
   assign rsp_valid = r_reg.rsp_valid;
   assign rsp_rdata = r_reg.rdata;
   assign rsp_granted = r_reg.granted;
   assign rsp_busy = r_reg.busy;
   assign mbox_int = r_reg.mbox;
   assign ram_addr = r_reg.addr;
   assign ram_dq_o = r_reg.dout;
   assign ram_dq_oe = r_reg.doe;
   assign chip_enable_n = r_reg.ce_n;
   assign token_select_n = r_reg.sem_n;
   assign write_strobe_n = r_reg.rw_n;
   assign output_enable_n = r_reg.oe_n;
   assign upper_byte_select_n = r_reg.upper_sel_n;
   assign lower_byte_select_n = r_reg.lower_sel_n;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   addr_stable_a: assert property ($changed(ram_addr) |-> write_strobe_n)
      else $error("address moved while write strobe low");
   array_select_a: assert property (!chip_enable_n |->
      token_select_n && !(upper_byte_select_n && lower_byte_select_n))
      else $error("array access without byte select or with token select");
   token_select_a: assert property (!token_select_n |-> chip_enable_n)
      else $error("token access with chip enable low");
   bus_turn_a: assert property (ram_dq_oe |-> output_enable_n)
      else $error("data driven while device output enabled");
   addr_before_ce_a: assert property ($fell(chip_enable_n) |->
      $stable(ram_addr) && write_strobe_n)
      else $error("address not settled when chip enable fell");
   token_frame_a: assert property ((!token_select_n && $fell(output_enable_n)) |->
      $fell(token_select_n))
      else $error("token read not framed by its own select pulse");
   token_ce_high_a: assert property ((r_reg.st != DPR_S_IDLE && is_token) |->
      chip_enable_n)
      else $error("chip enable low during token sequence");
   token_request_a: assert property ((!write_strobe_n && !token_select_n &&
      r_reg.kind == DPR_K_TREQ) |-> !ram_dq_o[0] && !lower_byte_select_n)
      else $error("token request not writing zero on bit 0");
   grant_readback_a: assert property ((rsp_valid && r_reg.kind == DPR_K_TREQ) |->
      rsp_granted == !rsp_rdata[0] && $past(r_reg.rdback, 4))
      else $error("grant does not follow read-back value");
   read_done_a: assert property ((cmd_valid && cmd_ready && cmd_kind == DPR_K_ARD)
      |-> ##[14:20] rsp_valid)
      else $error("array read did not answer in time");

   array_write_c: cover property (rsp_valid && r_reg.kind == DPR_K_AWR);
   token_won_c: cover property (rsp_valid && rsp_granted);
   token_lost_c: cover property (rsp_valid && r_reg.kind == DPR_K_TREQ && !rsp_granted);
   clash_seen_c: cover property (rsp_valid && rsp_busy);
endmodule : dpr_host

`default_nettype wire

// ==== tb/dpr_dev_model.sv ====
// behavioural model of one device port: ram array, token latches, flags
// assumes host pins settle between clock edges; device in master mode
`default_nettype none

module dpr_dev_model (
   // host pins
   input wire logic [dpr_pkg::DPR_ADDR_W-1:0] ram_addr,
   input wire logic [dpr_pkg::DPR_DATA_W-1:0] ram_dq_i,
   input wire logic chip_enable_n,
   input wire logic token_select_n,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic upper_byte_select_n,
   input wire logic lower_byte_select_n,
   // bench controls standing in for the other port
   input wire logic busy_req,
   input wire logic int_req,
   input wire logic other_tok,
   // device outputs
   output logic [dpr_pkg::DPR_DATA_W-1:0] dev_q,
   output logic dev_oe,
   output logic collision_n,
   output logic mailbox_int_n
);
   timeunit 1ns;
   timeprecision 100ps;
   import dpr_pkg::*;
   logic [DPR_DATA_W-1:0] mem [2**DPR_ADDR_W];
   logic [7:0] mine = 8'h00;
   wire arr_sel = !chip_enable_n && token_select_n
      && !(upper_byte_select_n && lower_byte_select_n);
   wire tok_sel = chip_enable_n && !token_select_n;
   wire tok_wr = tok_sel && !lower_byte_select_n;
   initial foreach (mem[i]) mem[i] = '0;
   // store at strobe end, data is still driven then
   always @(posedge write_strobe_n) begin
      if (arr_sel && !lower_byte_select_n) mem[ram_addr][7:0] = ram_dq_i[7:0];
      if (arr_sel && !upper_byte_select_n) mem[ram_addr][15:8] = ram_dq_i[15:8];
      if (tok_wr && ram_dq_i[0]) mine[ram_addr[2:0]] = 1'b0;
      // other port holding it always wins: one owner only
      if (tok_wr && !ram_dq_i[0] && !other_tok) mine[ram_addr[2:0]] = 1'b1;
   end
   assign dev_oe = !output_enable_n && write_strobe_n && (arr_sel || tok_sel);
   assign dev_q = tok_sel ? {{(DPR_DATA_W-1){1'b1}}, !mine[ram_addr[2:0]]} : mem[ram_addr];
   assign collision_n = !busy_req;
   assign mailbox_int_n = !int_req;
endmodule : dpr_dev_model

`default_nettype wire

// ==== tb/dpr_host_tb.sv ====
// self-checking bench for the dual-port ram host controller
// assumes dpr_dev_model on the far side; bench resolves the data wire
`default_nettype none

module dpr_host_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dpr_pkg::*;
   logic sys_clk, sys_rst, cmd_valid, cmd_ready, prev_we;
   dpr_kind_t cmd_kind;
   logic [12:0] cmd_addr, ram_addr, prev_addr;
   logic [15:0] cmd_wdata, rsp_rdata, ram_dq_o, ram_dq_i, dev_q, last_q;
   logic [1:0] cmd_be;
   logic rsp_valid, rsp_granted, rsp_busy, mbox_int, ram_dq_oe, dev_oe;
   logic chip_enable_n, token_select_n, write_strobe_n, output_enable_n;
   logic upper_byte_select_n, lower_byte_select_n, collision_n, mailbox_int_n;
   logic busy_req, int_req, other_tok;
   logic [15:0] shadow [8192];
   int bad_count, total_checks, cyc;
   // released wire shows the inverse of its last level
   assign ram_dq_i = ram_dq_oe ? ram_dq_o : dev_oe ? dev_q : ~last_q;

   dpr_host i_dpr_host (
      .sys_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr, .cmd_wdata, .cmd_be,
      .rsp_valid, .rsp_rdata, .rsp_granted, .rsp_busy, .mbox_int, .ram_addr, .ram_dq_o,
      .ram_dq_i, .ram_dq_oe, .chip_enable_n, .token_select_n, .write_strobe_n,
      .output_enable_n, .upper_byte_select_n, .lower_byte_select_n, .collision_n,
      .mailbox_int_n
   );
   dpr_dev_model i_dpr_dev_model (
      .ram_addr, .ram_dq_i, .chip_enable_n, .token_select_n, .write_strobe_n,
      .output_enable_n, .upper_byte_select_n, .lower_byte_select_n, .busy_req, .int_req,
      .other_tok, .dev_q, .dev_oe, .collision_n, .mailbox_int_n
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
      input logic [1:0] be);
      return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
   endfunction : merge

   // offered at a falling edge once idle, held over one edge, then answer awaited
   task automatic op(input dpr_kind_t k, input logic [12:0] a, input logic [15:0] d,
      input logic [1:0] be);
      while (cmd_ready !== 1'b1) @(negedge sys_clk);
      cmd_kind = k;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_be = be;
      cmd_valid = 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(negedge sys_clk);
      // one idle edge so the next offer never lands in this time step
      @(negedge sys_clk);
      if (k == DPR_K_AWR) shadow[a] = merge(shadow[a], d, be);
   endtask : op

   always @(posedge sys_clk) begin
      last_q <= ram_dq_i;
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         report_and_stop();
      end
   end

   always @(negedge sys_clk) begin
      if (!sys_rst) begin
         chk(16'(ram_addr != prev_addr && !(write_strobe_n && prev_we)), 16'h0);
         chk(16'(ram_dq_oe && dev_oe), 16'h0);
         chk(16'(!chip_enable_n && !token_select_n), 16'h0);
      end
      prev_addr <= ram_addr;
      prev_we <= write_strobe_n;
   end

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      logic [12:0] a;
      logic [15:0] d;
      logic [1:0] be;
      void'($urandom(16792));
      {sys_rst, cmd_valid, busy_req, int_req, other_tok} = 5'h10;
      cmd_kind = DPR_K_ARD;
      {cmd_addr, cmd_wdata, cmd_be, last_q, prev_addr, prev_we} = '0;
      {cyc, bad_count, total_checks} = '0;
      foreach (shadow[i]) shadow[i] = '0;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk({12'h0, chip_enable_n, token_select_n, write_strobe_n, ram_dq_oe}, 16'h000E);
      $display("test reset done");
      // small address range so reads hit earlier writes; top address as a corner
      for (int i = 0; i < 24; i++) begin
         a = (i % 4 == 0) ? 13'h1FFF : 13'($urandom_range(0, 7));
         d = 16'($urandom);
         be = 2'($urandom_range(0, 3));
         if ($urandom_range(0, 1) == 0) begin
            op(DPR_K_AWR, a, d, be);
         end else begin
            op(DPR_K_ARD, a, d, be);
            chk(rsp_rdata, shadow[a]);
         end
      end
      $display("test random done");
      op(DPR_K_TREQ, 13'h0003, 16'h0, 2'h1);
      chk(16'(rsp_granted), 16'h1);
      other_tok = 1'b1;
      op(DPR_K_TREQ, 13'h0005, 16'h0, 2'h1);
      chk(16'(rsp_granted), 16'h0);
      op(DPR_K_TREL, 13'h0003, 16'h0, 2'h1);
      other_tok = 1'b0;
      op(DPR_K_TREQ, 13'h0005, 16'h0, 2'h1);
      chk(16'(rsp_granted), 16'h1);
      op(DPR_K_ARD, 13'h0003, 16'h0, 2'h3);
      chk(rsp_rdata, shadow[3]);
      $display("test token done");
      busy_req = 1'b1;
      // let the flag pass the synchroniser before the write is offered
      repeat (6) @(negedge sys_clk);
      fork
         begin
            repeat (40) @(negedge sys_clk);
            chk(16'(write_strobe_n), 16'h1);
            chk(16'(cmd_ready), 16'h0);
            busy_req = 1'b0;
         end
         op(DPR_K_AWR, 13'h0002, 16'hA5C3, 2'h3);
      join
      chk(16'(rsp_busy), 16'h1);
      busy_req = 1'b1;
      op(DPR_K_ARD, 13'h0002, 16'h0, 2'h0);
      chk(rsp_rdata, 16'hA5C3);
      chk(16'(rsp_busy), 16'h1);
      busy_req = 1'b0;
      $display("test collision done");
      int_req = 1'b1;
      for (int n = 0; n < 10 && mbox_int !== 1'b1; n++) @(negedge sys_clk);
      chk(16'(mbox_int), 16'h1);
      int_req = 1'b0;
      for (int n = 0; n < 10 && mbox_int !== 1'b0; n++) @(negedge sys_clk);
      chk(16'(mbox_int), 16'h0);
      $display("test mailbox done");
      report_and_stop();
   end
endmodule : dpr_host_tb

`default_nettype wire
